// *** hw/fsrs_defines.svh ***
// Notes on behaviour
// - arm and reset opcodes are honoured only in single-line spi mode.
// - reset happens only when the reset opcode directly follows the arm opcode.
// - any command other than arm or reset after arming drops the armed state.
// - accepted reset aborts internal work and returns all but the write hold-off to power-on state.
// - accepted reset clears status, write latch, suspend, read and wrap fields.
// - after reset, recovery of 30 us with every command ignored.
// - busy flag reads one during erase, program or status write.
`ifndef FSRS_DEFINES_SVH
`define FSRS_DEFINES_SVH

// ==========================================================
// opcodes
`define FSRS_OP_ARM 8'h66
`define FSRS_OP_RESET 8'h99

// ==========================================================
// frame bit counter
`define FSRS_CNT_W 4
`define FSRS_CNT_BYTE 4'h8
`define FSRS_CNT_SAT 4'h9

// ==========================================================
// volatile field widths and reset values
`define FSRS_STAT_W 8
`define FSRS_RDPAR_W 8
`define FSRS_WRAP_W 3
`define FSRS_STAT_RST 8'h00
`define FSRS_RDPAR_RST 8'h00
`define FSRS_WRAP_RST 3'h0

// ==========================================================
// timing, ns and derived cycles
`define FSRS_CLK_NS 32'h0000_000A
`define FSRS_TRST_NS 32'h0000_7530
`define FSRS_PUW_NS 32'h004C_4B40
`define FSRS_TRST_CYC ((`FSRS_TRST_NS + `FSRS_CLK_NS - 1) / `FSRS_CLK_NS)
`define FSRS_PUW_CYC ((`FSRS_PUW_NS + `FSRS_CLK_NS - 1) / `FSRS_CLK_NS)
`define FSRS_TMR_W 20

`endif

// *** hw/fsrs_pkg.sv ***
`include "fsrs_defines.svh"
package fsrs_pkg;

   // ==========================================================
   // control states, one-hot
   typedef enum logic [2:0] {
      FSRS_IDLE = 3'b001,
      FSRS_ARMED = 3'b010,
      FSRS_RECOVER = 3'b100
   } fsrs_state_t;

   // ==========================================================
   // volatile settings held by the block
   typedef struct packed {
      logic [`FSRS_STAT_W-1:0] status_vol;
      logic write_enable_latch_flag;
      logic suspend_status_flag;
      logic [`FSRS_RDPAR_W-1:0] read_parameter_bits;
      logic [`FSRS_WRAP_W-1:0] wrap_setting_bits;
   } fsrs_vol_t;

   // update strobes from the command core
   typedef struct packed {
      logic status_we;
      logic [`FSRS_STAT_W-1:0] status_val;
      logic wel_set;
      logic wel_clr;
      logic sus_set;
      logic sus_clr;
      logic rdpar_we;
      logic [`FSRS_RDPAR_W-1:0] rdpar_val;
      logic wrap_we;
      logic [`FSRS_WRAP_W-1:0] wrap_val;
   } fsrs_upd_t;

   // frame word carried from the serial clock side
   typedef struct packed {
      logic [`FSRS_CNT_W-1:0] bits;
      logic [7:0] opcode;
   } fsrs_frame_t;

endpackage

// *** hw/fsrs_sync.sv ***
`timescale 1ns/1ps
module fsrs_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// *** hw/fsrs_top.sv ***
`timescale 1ns/1ps
`include "fsrs_defines.svh"
module fsrs_top
   import fsrs_pkg::*;
#(
   parameter int unsigned TRST_CYC = `FSRS_TRST_CYC,
   parameter int unsigned PUW_CYC = `FSRS_PUW_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic spi_single_mode,
   input wire logic core_op_active,
   input wire fsrs_upd_t vol_upd,
   output fsrs_vol_t vol,
   output logic armed,
   output logic reset_pulse,
   output logic recovery_busy,
   output logic busy_flag,
   output logic write_inhibit
);
   localparam int unsigned TW = `FSRS_TMR_W;
   localparam logic [TW-1:0] TRST_LAST = TW'(TRST_CYC - 1);
   localparam logic [TW-1:0] PUW_LAST = TW'(PUW_CYC - 1);

   // ==========================================================
   // serial clock side
   logic frame_rst;
   logic in_frame_q;
   fsrs_frame_t link_q;

   assign frame_rst = cs_n | ~rst_n;

   // clock stops between frames, so select high alone ends the frame
   always_ff @(posedge sclk or posedge frame_rst) begin
      if (frame_rst) begin
         in_frame_q <= 1'b0;
      end else begin
         in_frame_q <= 1'b1;
      end
   end

   // count and byte survive select high for the other side to read
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         link_q <= '0;
      end else if (!in_frame_q) begin
         link_q.bits <= `FSRS_CNT_W'(1);
         link_q.opcode <= {7'h00, sdi};
      end else begin
         if (link_q.bits != `FSRS_CNT_SAT) begin
            link_q.bits <= link_q.bits + `FSRS_CNT_W'(1);
         end
         link_q.opcode <= {link_q.opcode[6:0], sdi};
      end
   end

   // ==========================================================
   // crossing: select level syncs, frame word is static by then
   logic cs_sync;
   logic cs_prev_q;
   fsrs_frame_t frame_sync;

   fsrs_sync #(.WIDTH(1)) u_cs_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(cs_n),
      .q(cs_sync)
   );

   fsrs_sync #(.WIDTH($bits(fsrs_frame_t))) u_frame_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(link_q),
      .q(frame_sync)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_prev_q <= 1'b1;
      end else if (ce) begin
         cs_prev_q <= cs_sync;
      end
   end

   // ==========================================================
   // frame decode
   logic frame_end;
   logic exact8;
   logic long_cmd;
   logic is_arm;
   logic is_reset;
   logic other_cmd;

   assign frame_end = ce & cs_sync & ~cs_prev_q;
   assign exact8 = frame_sync.bits == `FSRS_CNT_BYTE;
   assign long_cmd = frame_sync.bits > `FSRS_CNT_BYTE;
   assign is_arm = exact8 & spi_single_mode
      & (frame_sync.opcode == `FSRS_OP_ARM);
   assign is_reset = exact8 & spi_single_mode
      & (frame_sync.opcode == `FSRS_OP_RESET);
   assign other_cmd = (exact8 | long_cmd) & ~is_arm & ~is_reset;

   // ==========================================================
   // sequencer
   fsrs_state_t state_q;
   fsrs_state_t state_d;
   logic accept;
   logic [TW-1:0] rec_cnt_q;
   logic rec_done;

   assign rec_done = rec_cnt_q == TRST_LAST;

   always_comb begin
      state_d = state_q;
      accept = 1'b0;
      case (state_q)
         FSRS_IDLE: begin
            if (frame_end && is_arm) begin
               state_d = FSRS_ARMED;
            end
         end
         FSRS_ARMED: begin
            if (frame_end && is_reset) begin
               state_d = FSRS_RECOVER;
               accept = 1'b1;
            end else if (frame_end && other_cmd) begin
               state_d = FSRS_IDLE;
            end
         end
         FSRS_RECOVER: begin
            // frames in here are dropped, not queued
            if (ce && rec_done) begin
               state_d = FSRS_IDLE;
            end
         end
         default: begin
            state_d = FSRS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= FSRS_IDLE;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rec_cnt_q <= '0;
      end else if (ce) begin
         if (state_q != FSRS_RECOVER || rec_done) begin
            rec_cnt_q <= '0;
         end else begin
            rec_cnt_q <= rec_cnt_q + TW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reset_pulse <= 1'b0;
      end else if (ce) begin
         reset_pulse <= accept;
      end
   end

   assign armed = state_q == FSRS_ARMED;
   assign recovery_busy = state_q == FSRS_RECOVER;

   // ==========================================================
   // volatile settings
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vol.status_vol <= `FSRS_STAT_RST;
         vol.write_enable_latch_flag <= 1'b0;
         vol.suspend_status_flag <= 1'b0;
         vol.read_parameter_bits <= `FSRS_RDPAR_RST;
         vol.wrap_setting_bits <= `FSRS_WRAP_RST;
      end else if (ce) begin
         if (accept) begin
            vol.status_vol <= `FSRS_STAT_RST;
            vol.write_enable_latch_flag <= 1'b0;
            vol.suspend_status_flag <= 1'b0;
            vol.read_parameter_bits <= `FSRS_RDPAR_RST;
            vol.wrap_setting_bits <= `FSRS_WRAP_RST;
         end else if (state_q != FSRS_RECOVER) begin
            if (vol_upd.status_we) begin
               vol.status_vol <= vol_upd.status_val;
            end
            // set beats clear when both strobe together
            if (vol_upd.wel_set) begin
               vol.write_enable_latch_flag <= 1'b1;
            end else if (vol_upd.wel_clr) begin
               vol.write_enable_latch_flag <= 1'b0;
            end
            if (vol_upd.sus_set) begin
               vol.suspend_status_flag <= 1'b1;
            end else if (vol_upd.sus_clr) begin
               vol.suspend_status_flag <= 1'b0;
            end
            if (vol_upd.rdpar_we) begin
               vol.read_parameter_bits <= vol_upd.rdpar_val;
            end
            if (vol_upd.wrap_we) begin
               vol.wrap_setting_bits <= vol_upd.wrap_val;
            end
         end
      end
   end

   // ==========================================================
   // busy flag, dropped at once by an accepted reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_flag <= 1'b0;
      end else if (ce) begin
         busy_flag <= core_op_active & ~accept
            & (state_q != FSRS_RECOVER);
      end
   end

   // ==========================================================
   // power-up write hold-off, a courtesy guard for hosts that rush
   logic [TW-1:0] puw_cnt_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         puw_cnt_q <= '0;
         write_inhibit <= 1'b1;
      end else if (ce && write_inhibit) begin
         puw_cnt_q <= puw_cnt_q + TW'(1);
         write_inhibit <= puw_cnt_q != PUW_LAST;
      end
   end

   // ==========================================================
   // checks
   int unsigned rec_len_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rec_len_q <= 0;
      end else if (ce) begin
         rec_len_q <= recovery_busy ? rec_len_q + 1 : 0;
      end
   end

   sequence s_arm_frame;
      frame_end && is_arm && state_q == FSRS_IDLE;
   endsequence

   sequence s_reset_frame;
      frame_end && is_reset && state_q == FSRS_ARMED;
   endsequence

   property p_arm;
      @(posedge clk) disable iff (!rst_n)
      s_arm_frame |=> armed;
   endproperty
   a_arm: assert property (p_arm)
      else $error("arm opcode did not arm");

   property p_reset_accept;
      @(posedge clk) disable iff (!rst_n)
      s_reset_frame |=> reset_pulse && recovery_busy;
   endproperty
   a_reset_accept: assert property (p_reset_accept)
      else $error("reset after arm was not accepted");

   property p_reset_needs_arm;
      @(posedge clk) disable iff (!rst_n)
      $rose(reset_pulse) |-> $past(state_q) == FSRS_ARMED;
   endproperty
   a_reset_needs_arm: assert property (p_reset_needs_arm)
      else $error("reset pulse without prior arm");

   property p_disarm;
      @(posedge clk) disable iff (!rst_n)
      frame_end && armed && other_cmd |=> !armed && !reset_pulse;
   endproperty
   a_disarm: assert property (p_disarm)
      else $error("other command left device armed");

   property p_mode;
      @(posedge clk) disable iff (!rst_n)
      frame_end && !spi_single_mode && state_q == FSRS_IDLE
         |=> !armed;
   endproperty
   a_mode: assert property (p_mode)
      else $error("armed outside single-line mode");

   property p_vol_clear;
      @(posedge clk) disable iff (!rst_n)
      reset_pulse |-> vol == {`FSRS_STAT_RST, 1'b0, 1'b0,
         `FSRS_RDPAR_RST, `FSRS_WRAP_RST};
   endproperty
   a_vol_clear: assert property (p_vol_clear)
      else $error("volatile settings not cleared");

   property p_abort;
      @(posedge clk) disable iff (!rst_n)
      reset_pulse |-> !busy_flag ##1 (!busy_flag || !ce) [*3];
   endproperty
   a_abort: assert property (p_abort)
      else $error("busy survived reset");

   property p_recovery_len;
      @(posedge clk) disable iff (!rst_n)
      $fell(recovery_busy) |-> rec_len_q == TRST_CYC;
   endproperty
   a_recovery_len: assert property (p_recovery_len)
      else $error("recovery length wrong");

   property p_ignore;
      @(posedge clk) disable iff (!rst_n)
      recovery_busy && !rec_done |=> recovery_busy && !armed;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("command taken during recovery");

   property p_short_frame;
      @(posedge clk) disable iff (!rst_n)
      frame_end && frame_sync.bits < `FSRS_CNT_BYTE
         && !recovery_busy |=> $stable(state_q);
   endproperty
   a_short_frame: assert property (p_short_frame)
      else $error("short frame changed state");

   property p_busy;
      @(posedge clk) disable iff (!rst_n)
      ce && core_op_active && !recovery_busy && !accept |=> busy_flag;
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy flag missing during operation");

endmodule

// *** sim/fsrs_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// spi host stand-in: single-line frames, msb first
module fsrs_host_model (
   output logic cs_n,
   output logic sclk,
   output logic sdi
);
   // serial clock stands still outside frames
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   // n other than 8 makes a malformed frame on purpose
   task automatic frame(input logic [7:0] op, input int n);
      logic [8:0] w;
      w = {op, 1'b0};
      #7;
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdi = w[8-i];
         #40 sclk = 1'b1;
         #40 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      // released line must not keep its last value
      sdi = ~sdi;
      // deselect gap well above four system clocks
      #100;
   endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb
   import fsrs_pkg::*;
;
   localparam int TRST = 120;
   localparam int PUW = 50;
   logic clk = 1'b0;
   logic rst_n;
   logic ce;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic spi_single_mode;
   logic core_op_active;
   fsrs_upd_t vol_upd;
   fsrs_vol_t vol;
   fsrs_vol_t exp_vol;
   fsrs_upd_t u;
   logic armed;
   logic reset_pulse;
   logic recovery_busy;
   logic busy_flag;
   logic write_inhibit;
   int mismatches = 0;
   int total_checks = 0;
   int pulses = 0;
   int rcnt = 0;
   int r0;

   // ==========================================================
   // clock and instances
   // recovery kept longer than one frame so a frame fits inside it
   always #5 clk = ~clk;

   fsrs_top #(.TRST_CYC(TRST), .PUW_CYC(PUW)) uut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi), .spi_single_mode(spi_single_mode),
      .core_op_active(core_op_active), .vol_upd(vol_upd), .vol(vol),
      .armed(armed), .reset_pulse(reset_pulse),
      .recovery_busy(recovery_busy), .busy_flag(busy_flag),
      .write_inhibit(write_inhibit)
   );

   fsrs_host_model host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi));

   // pulse cycles and recovery cycles counted on every rising clock edge
   always @(posedge clk) begin
      if (reset_pulse === 1'b1) pulses <= pulses + 1;
      if (recovery_busy === 1'b1) rcnt <= rcnt + 1;
   end

   // ==========================================================
   // tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] op, input int n);
      host.frame(op, n);
      cyc(6);
   endtask

   task automatic upd(input fsrs_upd_t x);
      vol_upd = x;
      cyc(1);
      vol_upd = '0;
      cyc(2);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 300 && recovery_busy !== 1'b0; i++) cyc(1);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================
   // watchdog, far beyond the expected run of about 17 us
   initial begin
      #200000;
      mismatches++;
      stop_test();
   end

   // ==========================================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      spi_single_mode = 1'b1;
      core_op_active = 1'b0;
      vol_upd = '0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      cyc(2);
      chk(32'(vol), 32'h0, "vol after reset");
      chk(32'(armed), 32'h0, "armed after reset");
      chk(32'(write_inhibit), 32'h1, "inhibit at power-up");
      cyc(PUW + 5);
      chk(32'(write_inhibit), 32'h0, "inhibit after delay");
      // framing
      cmd(8'h66, 7);
      chk(32'(armed), 32'h0, "short frame arms");
      cmd(8'h66, 9);
      chk(32'(armed), 32'h0, "long frame arms");
      cmd(8'h66, 8);
      chk(32'(armed), 32'h1, "arm missing");
      cmd(8'h66, 8);
      chk(32'(armed), 32'h1, "repeat arm drops");
      cmd(8'h05, 8);
      chk(32'(armed), 32'h0, "other cmd keeps arm");
      cmd(8'h99, 8);
      chk(32'(pulses), 32'h0, "reset without arm");
      cmd(8'h66, 8);
      cmd(8'h99, 9);
      chk(32'(armed), 32'h0, "long reset keeps arm");
      chk(32'(pulses), 32'h0, "long reset accepted");
      // opcodes outside single-line mode
      spi_single_mode = 1'b0;
      cmd(8'h66, 8);
      chk(32'(armed), 32'h0, "arm in multi mode");
      spi_single_mode = 1'b1;
      cmd(8'h66, 8);
      spi_single_mode = 1'b0;
      cmd(8'h99, 8);
      chk(32'(pulses), 32'h0, "reset in multi mode");
      chk(32'(armed), 32'h0, "multi mode keeps arm");
      spi_single_mode = 1'b1;
      // clock enable freezes updates
      u = '0;
      u.wel_set = 1'b1;
      ce = 1'b0;
      upd(u);
      ce = 1'b1;
      chk(32'(vol), 32'h0, "update while frozen");
      // load every volatile field, then start an internal op
      u = '0;
      u.status_we = 1'b1;
      u.status_val = 8'hA5;
      u.wel_set = 1'b1;
      u.sus_set = 1'b1;
      u.rdpar_we = 1'b1;
      u.rdpar_val = 8'h3C;
      u.wrap_we = 1'b1;
      u.wrap_val = 3'h5;
      upd(u);
      exp_vol = '{8'hA5, 1'b1, 1'b1, 8'h3C, 3'h5};
      chk(32'(vol), 32'(exp_vol), "vol load");
      // clear strobes alone, then set and clear together: set must win
      u = '0;
      u.wel_clr = 1'b1;
      u.sus_clr = 1'b1;
      upd(u);
      exp_vol.write_enable_latch_flag = 1'b0;
      exp_vol.suspend_status_flag = 1'b0;
      chk(32'(vol), 32'(exp_vol), "flag clear");
      u.wel_set = 1'b1;
      u.sus_set = 1'b1;
      upd(u);
      exp_vol.write_enable_latch_flag = 1'b1;
      exp_vol.suspend_status_flag = 1'b1;
      chk(32'(vol), 32'(exp_vol), "set beats clear");
      core_op_active = 1'b1;
      cyc(2);
      chk(32'(busy_flag), 32'h1, "busy during op");
      // reset in mid-operation
      cmd(8'h66, 8);
      r0 = rcnt;
      cmd(8'h99, 8);
      chk(32'(pulses), 32'h1, "one-cycle pulse");
      chk(32'(recovery_busy), 32'h1, "recovery start");
      chk(32'(vol), 32'h0, "vol not cleared");
      chk(32'(busy_flag), 32'h0, "op not aborted");
      chk(32'(armed), 32'h0, "armed after reset");
      // everything ignored while recovering
      u = '0;
      u.wel_set = 1'b1;
      upd(u);
      chk(32'(vol), 32'h0, "update in recovery");
      cmd(8'h66, 8);
      chk(32'(armed), 32'h0, "arm in recovery");
      core_op_active = 1'b0;
      wait_idle();
      chk(32'(rcnt - r0), 32'(TRST), "recovery length");
      // host checks busy first, then a full sequence works again
      cyc(2);
      chk(32'(busy_flag), 32'h0, "busy before reset");
      cmd(8'h66, 8);
      chk(32'(armed), 32'h1, "rearm after recovery");
      cmd(8'h99, 8);
      chk(32'(pulses), 32'h2, "second reset");
      wait_idle();
      chk(32'(recovery_busy), 32'h0, "recovery never ends");
      // mid-run reset drops the armed state and restarts the hold-off
      cmd(8'h66, 8);
      chk(32'(armed), 32'h1, "arm after second recovery");
      rst_n = 1'b0;
      cyc(2);
      rst_n = 1'b1;
      cyc(2);
      chk(32'(armed), 32'h0, "armed kept over reset");
      chk(32'(write_inhibit), 32'h1, "hold-off not restarted");
      stop_test();
   end
endmodule
